// *** adc_gain_mute_diag_defs.vh ***
`ifndef ADC_GAIN_MUTE_DIAG_DEFS_VH
`define ADC_GAIN_MUTE_DIAG_DEFS_VH
// register offsets
`define GAIN_CHANNEL_ONE_ADDR   8'h0a
`define GAIN_CHANNEL_TWO_ADDR   8'h0b
`define GAIN_CHANNEL_THREE_ADDR 8'h0c
`define GAIN_CHANNEL_FOUR_ADDR  8'h0d
`define SUM_MUTE_CAL_ADDR       8'h0e
`define FAULT_DETECT_EN_ADDR    8'h10
// reset values
`define GAIN_RESET              8'ha0
`define SUM_MUTE_CAL_RESET      8'h02
`define FAULT_DETECT_EN_RESET   8'h0f
// gain code landmarks
`define GAIN_CODE_MAX_BOOST     8'h00
`define GAIN_CODE_UNITY         8'ha0
`define GAIN_CODE_MUTE          8'hff
// gain step is 0.375 dB = 3/8 dB; gain reported in eighths of a dB
`define GAIN_STEP_EIGHTHS       11'h003
`define GAIN_TOP_EIGHTHS        11'h1e0
// field positions in the misc control register
`define COMBINE_MSB             7
`define COMBINE_LSB             6
`define SILENCE_BIT             4
`define CAL_BIT                 0
// fault detect enable field in the fault_detect_enable register
`define FAULT_EN_MSB            3
`define FAULT_EN_LSB            0
// decoded gain of a unity code, in eighths of a dB
`define UNITY_EIGHTHS           11'h000
// combine modes
`define COMBINE_FOUR            2'h0
`define COMBINE_TWO             2'h1
`define COMBINE_ONE             2'h2
`define COMBINE_RSVD            2'h3
`endif

// *** adc_gain_mute_fault_detect_enable.v ***
// Function
// - code zero is +60 dB, steps -0.375 dB
// - code 0xa0 is unity, 0x9f +0.375 dB
// - code 0xfe is -35.25 dB, 0xff mutes
// - four gain registers from 0x0a, reset 0xa0
// - bits 7:6 select four, two or one channel
// - master mute bit 4 silences all channels
// - misc control at 0x0e resets to 0x02
// - diag register bits 3:0 enable channel diagnostics
// - fault_detect_enable at 0x10 resets to 0x0f
`timescale 1ns/1ps
`include "adc_gain_mute_diag_defs.vh"

module adc_gain_mute_fault_detect_enable (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset,
    // control port register access, same clock domain
    input  wire        i_wr_en,
    input  wire        i_rd_en,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wr_data,
    output reg  [7:0]  o_rd_data,
    output reg         o_rd_valid,
    // raw gain codes per channel
    output reg  [7:0]  o_ch1_gain_code,
    output reg  [7:0]  o_ch2_gain_code,
    output reg  [7:0]  o_ch3_gain_code,
    output reg  [7:0]  o_ch4_gain_code,
    // decoded gain in eighths of a dB, signed, and per-channel mute
    output reg  [43:0] o_gain_eighths,
    output reg  [3:0]  o_ch_muted,
    // misc control fields
    output reg  [1:0]  o_channel_combine_select,
    output reg         o_combine_reserved,
    output reg         o_global_silence,
    output reg         o_offset_calibrate_request,
    // per-channel fault detect enables, bit 0 is channel 1
    output reg  [3:0]  o_fault_detect_on
);

    // selector codes produced by the address decoder
    localparam [2:0] SEL_GAIN1 = 3'h0;    // gain, channel 1
    localparam [2:0] SEL_GAIN2 = 3'h1;    // gain, channel 2
    localparam [2:0] SEL_GAIN3 = 3'h2;    // gain, channel 3
    localparam [2:0] SEL_GAIN4 = 3'h3;    // gain, channel 4
    localparam [2:0] SEL_MISC  = 3'h4;    // combine, mute and calibrate
    localparam [2:0] SEL_DIAG  = 3'h5;    // fault detect enables
    localparam [2:0] SEL_NONE  = 3'h7;    // unmapped, including the hole at 0x0f

    // stored register bytes; kept whole so reserved bits read back as written
    reg [7:0]  gain_q [0:3];   // per-channel gain codes, index 0 is channel 1
    reg [7:0]  misc_q;         // combine field, master mute, reserved bits, calibrate
    reg [7:0]  diag_q;         // fault detect enables, reserved upper nibble

    // decoded address and fields pulled out of the stored bytes
    wire [2:0] addr_sel;       // register picked by the current address
    wire [1:0] combine_field;  // channel arrangement code
    wire       silence_field;  // master mute
    wire       cal_field;      // offset calibration request
    wire [3:0] fault_field;    // fault detect enables, bit 0 is channel 1

    // loop indices, one per process so neither has two drivers
    integer    k;              // walks the gain array in the write process
    integer    n;              // walks the channels in the decode process

    // map an address onto a register selector; shared by write and read
    function [2:0] reg_index;
        input [7:0] addr;
        begin
            case (addr)
                `GAIN_CHANNEL_ONE_ADDR:   reg_index = SEL_GAIN1;
                `GAIN_CHANNEL_TWO_ADDR:   reg_index = SEL_GAIN2;
                `GAIN_CHANNEL_THREE_ADDR: reg_index = SEL_GAIN3;
                `GAIN_CHANNEL_FOUR_ADDR:  reg_index = SEL_GAIN4;
                `SUM_MUTE_CAL_ADDR:       reg_index = SEL_MISC;
                `FAULT_DETECT_EN_ADDR:    reg_index = SEL_DIAG;
                // 0x0f and everything else fall through to no register
                default:                  reg_index = SEL_NONE;
            endcase
        end
    endfunction

    // gain in signed eighths of a dB: +480 at code zero, minus 3 per code step
    // 11 bits cover +480 down to -285, so the all-ones code still decodes
    function [10:0] code_to_eighths;
        input [7:0] code;
        begin
            code_to_eighths = `GAIN_TOP_EIGHTHS - ({3'h0, code} * `GAIN_STEP_EIGHTHS);
        end
    endfunction

    // a channel is silent when its code is all ones or master mute is on
    function is_muted;
        input [7:0] code;
        input       silence;
        begin
            is_muted = (code == `GAIN_CODE_MUTE) || silence;
        end
    endfunction

    // decode once per cycle; the strobes qualify it in each process
    assign addr_sel = reg_index(i_addr);

    // fields of the stored bytes, named for the output logic below
    assign combine_field = misc_q[`COMBINE_MSB:`COMBINE_LSB];
    assign silence_field = misc_q[`SILENCE_BIT];
    assign cal_field     = misc_q[`CAL_BIT];
    assign fault_field   = diag_q[`FAULT_EN_MSB:`FAULT_EN_LSB];

    // register writes; an unmapped address stores nothing
    // reserved bits are stored as written, so software must keep them itself
    always @(posedge i_clk) begin
        if (i_reset) begin
            // every channel starts at unity gain
            for (k = 0; k < 4; k = k + 1) begin
                gain_q[k] <= `GAIN_RESET;
            end
            misc_q <= `SUM_MUTE_CAL_RESET;
            diag_q <= `FAULT_DETECT_EN_RESET;
        end else if (i_wr_en) begin
            case (addr_sel)
                SEL_GAIN1: begin
                    gain_q[0] <= i_wr_data;
                end
                SEL_GAIN2: begin
                    gain_q[1] <= i_wr_data;
                end
                SEL_GAIN3: begin
                    gain_q[2] <= i_wr_data;
                end
                SEL_GAIN4: begin
                    gain_q[3] <= i_wr_data;
                end
                SEL_MISC: begin
                    misc_q <= i_wr_data;
                end
                SEL_DIAG: begin
                    diag_q <= i_wr_data;
                end
                default: begin
                    // unmapped write is dropped without any error indication
                end
            endcase
        end
    end

    // read path: one cycle latency; a read beside a write returns the old byte
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_rd_data  <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            // valid is a one-cycle pulse per read strobe
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                case (addr_sel)
                    SEL_GAIN1: o_rd_data <= gain_q[0];
                    SEL_GAIN2: o_rd_data <= gain_q[1];
                    SEL_GAIN3: o_rd_data <= gain_q[2];
                    SEL_GAIN4: o_rd_data <= gain_q[3];
                    SEL_MISC:  o_rd_data <= misc_q;
                    SEL_DIAG:  o_rd_data <= diag_q;
                    // unmapped reads give zero so a probe sees no stale byte
                    default:   o_rd_data <= 8'h00;
                endcase
            end
            // otherwise the last read byte stands until the next read
        end
    end

    // raw gain codes, one cycle behind the stored bytes
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_ch1_gain_code <= `GAIN_RESET;
            o_ch2_gain_code <= `GAIN_RESET;
            o_ch3_gain_code <= `GAIN_RESET;
            o_ch4_gain_code <= `GAIN_RESET;
        end else begin
            o_ch1_gain_code <= gain_q[0];
            o_ch2_gain_code <= gain_q[1];
            o_ch3_gain_code <= gain_q[2];
            o_ch4_gain_code <= gain_q[3];
        end
    end

    // decoded gain and per-channel mute; registered so the outputs come from flops
    // the extra cycle costs nothing here, since gain changes are far slower
    always @(posedge i_clk) begin
        if (i_reset) begin
            // unity on every channel
            o_gain_eighths <= {4{`UNITY_EIGHTHS}};
            o_ch_muted     <= 4'h0;
        end else begin
            for (n = 0; n < 4; n = n + 1) begin
                // 0xa0 lands on zero and 0x9f on +3 eighths
                o_gain_eighths[n*11 +: 11] <= code_to_eighths(gain_q[n]);
                // master mute overrides every channel's code
                o_ch_muted[n] <= is_muted(gain_q[n], silence_field);
            end
        end
    end

    // misc control outputs, one cycle after the register write
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_channel_combine_select   <= `COMBINE_FOUR;
            o_combine_reserved         <= 1'b0;
            o_global_silence           <= 1'b0;
            o_offset_calibrate_request <= 1'b0;
        end else begin
            o_channel_combine_select <= combine_field;
            // reserved combine code flagged so downstream keeps four channels
            o_combine_reserved <= (combine_field == `COMBINE_RSVD);
            o_global_silence   <= silence_field;
            // level request, not self-clearing; software lowers the bit when done
            o_offset_calibrate_request <= cal_field;
        end
    end

    // fault detect enables, bit 0 is channel 1
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_fault_detect_on <= 4'hf; // all four enabled
        end else begin
            o_fault_detect_on <= fault_field;
        end
    end

endmodule // adc_gain_mute_fault_detect_enable

// *** adc_gain_mute_fault_detect_enable_sva.sv ***
`timescale 1ns/1ps
// a write lands in the register, then one edge later on the outputs
module adc_gain_mute_fault_detect_enable_sva (
    input wire logic        i_clk, i_reset, i_wr_en, i_rd_en, o_rd_valid,
    input wire logic        o_combine_reserved, o_global_silence, o_offset_calibrate_request,
    input wire logic [7:0]  i_addr, i_wr_data, o_ch1_gain_code,
    input wire logic [43:0] o_gain_eighths,
    input wire logic [3:0]  o_ch_muted, o_fault_detect_on,
    input wire logic [1:0]  o_channel_combine_select
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // write strobe aimed at one register
    sequence wr_to(a);
        i_wr_en && i_addr == a;
    endsequence
    AST_RD_PULSE: assert property (o_rd_valid == $past(i_rd_en))
        else $error("read valid out of step");
    AST_GAIN_WR: assert property (wr_to(8'h0a) |-> ##2 o_ch1_gain_code == $past(i_wr_data, 2))
        else $error("gain write lost");
    AST_COMBINE: assert property (wr_to(8'h0e) |-> ##2 o_channel_combine_select == $past(i_wr_data[7:6], 2))
        else $error("combine field wrong");
    AST_SILENCE: assert property (wr_to(8'h0e) |-> ##2 o_global_silence == $past(i_wr_data[4], 2))
        else $error("master mute wrong");
    AST_CAL: assert property (wr_to(8'h0e) |-> ##2 o_offset_calibrate_request == $past(i_wr_data[0], 2))
        else $error("calibrate request wrong");
    AST_DIAG: assert property (wr_to(8'h10) |-> ##2 o_fault_detect_on == $past(i_wr_data[3:0], 2))
        else $error("fault enables wrong");
    AST_MUTE: assert property (o_ch_muted[0] == (o_ch1_gain_code == 8'hff || o_global_silence))
        else $error("channel mute wrong");
    AST_EIGHTHS: assert property (o_ch1_gain_code != 8'hff |-> o_gain_eighths[10:0] == 11'h1e0 - 11'h003 * o_ch1_gain_code)
        else $error("gain decode wrong");
    AST_RSVD: assert property (o_combine_reserved == (o_channel_combine_select == 2'h3))
        else $error("reserved flag wrong");
endmodule // adc_gain_mute_fault_detect_enable_sva
bind adc_gain_mute_fault_detect_enable adc_gain_mute_fault_detect_enable_sva u_sva (.*);

// *** adc_gain_mute_fault_detect_enable_tb_top.sv ***
`timescale 1ns/1ps
module adc_gain_mute_fault_detect_enable_tb_top;
    logic        i_clk = 0, i_reset = 1, i_wr_en = 0, i_rd_en = 0, rv, rsv, sil, cal;
    logic [7:0]  i_addr = 0, i_wr_data = 0, o_rd_data, g1, g2, g3, g4, m[7];
    logic [7:0]  cg[5] = '{8'h00, 8'h9f, 8'ha0, 8'hfe, 8'hff};
    logic [43:0] o_gain_eighths;
    logic [3:0]  o_ch_muted, o_fault_detect_on;
    logic [1:0]  sel;
    int          fails = 0, checks_done = 0, k, j;
    adc_gain_mute_fault_detect_enable DUT (.i_clk, .i_reset, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data,
        .o_rd_data, .o_rd_valid(rv), .o_ch1_gain_code(g1), .o_ch2_gain_code(g2),
        .o_ch3_gain_code(g3), .o_ch4_gain_code(g4), .o_gain_eighths, .o_ch_muted,
        .o_channel_combine_select(sel), .o_combine_reserved(rsv), .o_global_silence(sil),
        .o_offset_calibrate_request(cal), .o_fault_detect_on);
    initial forever #50 i_clk = ~i_clk;
    // index 6 is the unmapped hole at 0x0f
    function logic [7:0] ad(int i);
        return i == 5 ? 8'h10 : i == 6 ? 8'h0f : 8'h0a + i[7:0];
    endfunction
    function logic [10:0] ei(logic [7:0] c);
        return 11'h1e0 - 11'h003 * c;
    endfunction
    // expected mute per channel: all-ones code or master mute
    function logic [3:0] mu();
        logic [3:0] r;
        for (int c = 0; c < 4; c++) r[c] = m[c] == 8'hff || m[4][4];
        return r;
    endfunction
    task chk(string n, logic [43:0] e, logic [43:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // strobe one cycle, then an idle edge so outputs have settled
    task wr(int i, logic [7:0] d);
        i_wr_en = 1;
        i_addr = ad(i);
        i_wr_data = d;
        @(posedge i_clk);
        #1 i_wr_en = 0;
        @(posedge i_clk);
        #1;
        if (i < 6) m[i] = d;
    endtask
    task rd(int i);
        i_rd_en = 1;
        i_addr = ad(i);
        @(posedge i_clk);
        #1 i_rd_en = 0;
        chk("rd_valid", 1, rv);
        chk("rd_data", m[i], o_rd_data);
        @(posedge i_clk);
        #1;
    endtask
    initial begin
        k = $urandom(58909);
        m = '{8'ha0, 8'ha0, 8'ha0, 8'ha0, 8'h02, 8'h0f, 8'h00};
        repeat (3) @(posedge i_clk);
        #1 i_reset = 0;
        for (k = 0; k < 7; k++) rd(k);
        chk("fault_on", 4'hf, o_fault_detect_on);
        for (j = 0; j < 5; j++) begin
            wr(j % 4, cg[j]);
            if (j < 4) chk("gain", ei(cg[j]), o_gain_eighths[11*j +: 11]);
            chk("muted", {3'h0, j == 4}, o_ch_muted);
        end
        for (j = 0; j < 4; j++) begin
            wr(4, {j[1:0], 6'h13});
            chk("misc", {j[1:0], j == 3, 2'h3, 4'hf}, {sel, rsv, sil, cal, o_ch_muted});
        end
        wr(4, 8'h02);
        chk("unmute", 4'h1, o_ch_muted);
        wr(5, 8'ha6);
        chk("fault_on", 4'h6, o_fault_detect_on);
        repeat (40) begin
            k = $urandom % 7;
            wr(k, 8'($urandom));
            rd(k);
            chk("ctl", {m[5][3:0], m[4][0]}, {o_fault_detect_on, cal});
            chk("codes", {m[3], m[2], m[1], m[0]}, {g4, g3, g2, g1});
            chk("eighths", {ei(m[3]), ei(m[2]), ei(m[1]), ei(m[0])}, o_gain_eighths);
            chk("muted", mu(), o_ch_muted);
            chk("combine", {m[4][7:6], m[4][7:6] == 2'h3, m[4][4]}, {sel, rsv, sil});
        end
        // mid-run reset from a dirty state
        i_reset = 1;
        repeat (3) @(posedge i_clk);
        #1 i_reset = 0;
        m = '{8'ha0, 8'ha0, 8'ha0, 8'ha0, 8'h02, 8'h0f, 8'h00};
        chk("reset_codes", {4{8'ha0}}, {g1, g2, g3, g4});
        chk("reset_gain", 44'h0, o_gain_eighths);
        chk("reset_ctl", 14'h000f, {o_ch_muted, sel, rsv, sil, cal, rv, o_fault_detect_on});
        for (k = 0; k < 7; k++) rd(k);
        stop_test;
    end
    initial begin
        #500000;
        fails++;
        stop_test;
    end
endmodule // adc_gain_mute_fault_detect_enable_tb_top
